// File: cog_guard.sv
// Close-onto-fault guard: arms on an activation edge, trips instantly on a
// trigger while armed, and keeps events, counters and a record log.
// Assumes pin inputs are asynchronous and setting/time inputs share i_clock.
`timescale 1ns/1ps

module cog_guard #(
    parameter int TICK_CYCLES = cog_pkg::TICK_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_arming_input,
    input wire logic i_guard_block_input,
    input wire logic i_fault_trigger_input,
    input wire logic [2:0] i_mode,
    input wire logic [1:0] i_force,
    input wire logic [2:0] i_setting_group_choice,
    input wire logic [cog_pkg::GROUPS*cog_pkg::REL_W-1:0] i_release_time_setting,
    input wire logic [cog_pkg::TS_W-1:0] i_timestamp,
    input wire logic [3:0] i_event_on_store,
    input wire logic [3:0] i_event_off_store,
    input wire logic [3:0] i_counter_clear,
    input wire logic [3:0] i_record_index,
    output logic o_guard_trip_output,
    output logic o_guard_armed_output,
    output logic [cog_pkg::REL_W-1:0] o_release_time_remaining,
    output logic [cog_pkg::REL_W-1:0] o_active_time,
    output logic [2:0] o_behaviour,
    output logic [2:0] o_condition,
    output logic [3:0] o_event_on,
    output logic [3:0] o_event_off,
    output logic [cog_pkg::TS_W-1:0] o_event_time,
    output logic [4*cog_pkg::CNT_W-1:0] o_counters,
    output logic [3:0] o_record_count,
    output logic [cog_pkg::TS_W-1:0] o_record_time,
    output logic [1:0] o_record_event,
    output logic [2:0] o_record_group,
    output logic [cog_pkg::REL_W-1:0] o_record_remaining,
    output logic [cog_pkg::REL_W-1:0] o_record_elapsed
);

    // -----------------------------------------------------------------
    // Input synchronisers.
    // -----------------------------------------------------------------
    // Only binary levels arrive; each passes two flops before use. (see R6)
    logic [2:0] sync_a;  // First stage, read only by the second.
    logic [2:0] sync_b;  // Second stage, safe to use.
    logic arm_prev;  // Previous synchronised activation level.

    // Two-flop synchroniser for activation, block and trigger.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            arm_prev <= 1'b0;
        end else begin
            sync_a <= {i_fault_trigger_input, i_guard_block_input, i_arming_input};
            sync_b <= sync_a;
            arm_prev <= sync_b[0];
        end
    end

    wire arm_lvl = sync_b[0];  // Activation level.
    wire blk_lvl = sync_b[1];  // Block input level.
    wire fault_lvl = sync_b[2];  // Trigger level.
    wire arm_edge = arm_lvl & ~arm_prev;  // Only a rise arms. (see R1)

    // -----------------------------------------------------------------
    // Mode decode.
    // -----------------------------------------------------------------
    wire mode_blocked = (i_mode == cog_pkg::COG_MODE_BLOCKED)
        | (i_mode == cog_pkg::COG_MODE_TEST_BLOCKED)
        | (i_mode == cog_pkg::COG_MODE_OFF);  // Suppress arming. (see R16)
    wire mode_test = (i_mode == cog_pkg::COG_MODE_TEST)
        | (i_mode == cog_pkg::COG_MODE_TEST_BLOCKED);  // No breaker drive. (see R16)
    wire blocked = blk_lvl | mode_blocked;  // Any blocking source. (see R4)
    wire mode_legal = (i_mode <= cog_pkg::COG_MODE_OFF);  // Unknown codes read as On.

    // -----------------------------------------------------------------
    // Millisecond time base.
    // -----------------------------------------------------------------
    logic [15:0] div_cnt;  // Divider count.
    wire tick = (div_cnt == 16'(TICK_CYCLES - 1));  // One-cycle ms enable.

    // Free-running divider producing the ms enable.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
        end
    end

    // -----------------------------------------------------------------
    // Release time of the group in use, read live. (see R14)
    // -----------------------------------------------------------------
    wire [cog_pkg::REL_W-1:0] rel_raw =
        i_release_time_setting[i_setting_group_choice*cog_pkg::REL_W +: cog_pkg::REL_W];
    wire [cog_pkg::REL_W-1:0] rel_time =
        (rel_raw > cog_pkg::REL_MAX_MS) ? cog_pkg::REL_MAX_MS : rel_raw;  // (see R3)

    // -----------------------------------------------------------------
    // Guard state machine.
    // -----------------------------------------------------------------
    cog_pkg::cog_state_t state;  // Current state.
    cog_pkg::cog_state_t next_state;  // Next state.
    logic [cog_pkg::REL_W-1:0] elapsed;  // Milliseconds spent armed.
    logic [cog_pkg::REL_W-1:0] next_elapsed;  // Next elapsed value.

    wire expired = (elapsed >= rel_time);  // Armed period is over. (see R3)
    wire armed = (state == cog_pkg::COG_ST_ARMED) | (state == cog_pkg::COG_ST_TRIPPED);
    wire start_ok = arm_edge & ~blocked & (rel_time != '0);  // Arming allowed. (see R4)

    // Next-state logic: arm on edge, trip on trigger, release on expiry.
    always_comb begin
        next_state = state;
        next_elapsed = elapsed;
        case (state)
            cog_pkg::COG_ST_IDLE: begin
                if (start_ok) begin  // see R1
                    next_state = cog_pkg::COG_ST_ARMED;
                    next_elapsed = '0;
                end
            end
            cog_pkg::COG_ST_ARMED, cog_pkg::COG_ST_TRIPPED: begin
                if (blocked) begin  // Block ends the armed period. (see R4)
                    next_state = cog_pkg::COG_ST_IDLE;
                end else if (expired & ~fault_lvl) begin  // see R15
                    next_state = cog_pkg::COG_ST_IDLE;
                end else if (fault_lvl) begin  // Instant trip while armed. (see R2)
                    next_state = cog_pkg::COG_ST_TRIPPED;
                end else begin
                    next_state = cog_pkg::COG_ST_ARMED;
                end
                if (tick & ~expired) begin
                    next_elapsed = elapsed + 21'h000001;
                end
            end
            default: begin
                next_state = cog_pkg::COG_ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state <= cog_pkg::COG_ST_IDLE;
            elapsed <= '0;
        end else begin
            state <= next_state;
            elapsed <= next_elapsed;
        end
    end

    // -----------------------------------------------------------------
    // Status flags with forcing applied. (see R8)
    // -----------------------------------------------------------------
    wire f_block = (i_force == cog_pkg::COG_FORCE_BLOCKED);  // Forced blocked.
    wire f_act = (i_force == cog_pkg::COG_FORCE_ACTIVE);  // Forced active.
    wire f_trip = (i_force == cog_pkg::COG_FORCE_TRIP);  // Forced trip.
    wire f_any = f_block | f_act | f_trip;  // Any forcing.
    wire tripped = (state == cog_pkg::COG_ST_TRIPPED);  // Real trip.
    wire [3:0] flag;  // Init, block, active, trip.
    assign flag[cog_pkg::EV_INIT] = ~f_any & arm_lvl & ~blocked;
    assign flag[cog_pkg::EV_BLOCK] = f_any ? f_block : blocked;
    assign flag[cog_pkg::EV_ACTIVE] = f_any ? (f_act | f_trip) : armed;
    assign flag[cog_pkg::EV_TRIP] = f_any ? f_trip : tripped;

    // Condition code, highest priority first. (see R9)
    wire [2:0] cond = flag[cog_pkg::EV_TRIP] ? cog_pkg::COG_COND_TRIP
        : flag[cog_pkg::EV_ACTIVE] ? cog_pkg::COG_COND_ACTIVE
        : flag[cog_pkg::EV_BLOCK] ? cog_pkg::COG_COND_BLOCKED
        : flag[cog_pkg::EV_INIT] ? cog_pkg::COG_COND_INIT
        : cog_pkg::COG_COND_NORMAL;

    logic [3:0] flag_prev;  // Flags one cycle ago.
    wire [3:0] rise = flag & ~flag_prev;  // ON edges.
    wire [3:0] fall = ~flag & flag_prev;  // OFF edges.

    // Registered status outputs; Test modes hold the breaker drive low.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            flag_prev <= 4'h0;
            o_guard_trip_output <= 1'b0;
            o_guard_armed_output <= 1'b0;
            o_condition <= cog_pkg::COG_COND_NORMAL;
            o_behaviour <= cog_pkg::COG_MODE_ON;
            o_release_time_remaining <= '0;
            o_active_time <= '0;
        end else begin
            flag_prev <= flag;
            o_guard_trip_output <= flag[cog_pkg::EV_TRIP] & ~mode_test;  // see R5
            o_guard_armed_output <= flag[cog_pkg::EV_ACTIVE];
            o_condition <= cond;  // see R9
            o_behaviour <= mode_legal ? i_mode : cog_pkg::COG_MODE_ON;  // see R7
            o_release_time_remaining <= (armed & ~expired) ? rel_time - elapsed : '0;
            o_active_time <= armed ? elapsed : '0;
        end
    end

    // -----------------------------------------------------------------
    // Events with per-event store selection. (see R10)
    // -----------------------------------------------------------------
    // Event pulses with the time stamp of their cycle.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_event_on <= 4'h0;
            o_event_off <= 4'h0;
            o_event_time <= '0;
        end else begin
            o_event_on <= rise & i_event_on_store;
            o_event_off <= fall & i_event_off_store;
            o_event_time <= i_timestamp;
        end
    end

    // -----------------------------------------------------------------
    // Cumulative counters, one per event. (see R11)
    // -----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_cnt
            logic [cog_pkg::CNT_W-1:0] cnt;  // Count of ON edges.
            // A count arriving with a clear restarts at one, so it is kept.
            always_ff @(posedge i_clock) begin
                if (i_srst) begin
                    cnt <= '0;
                end else if (i_counter_clear[g]) begin
                    cnt <= {{(cog_pkg::CNT_W-1){1'b0}}, rise[g]};
                end else if (rise[g]) begin
                    cnt <= cnt + 16'h0001;
                end
            end
            assign o_counters[g*cog_pkg::CNT_W +: cog_pkg::CNT_W] = cnt;
        end
    endgenerate

    // -----------------------------------------------------------------
    // Record log, written on each activation ON. (see R12)
    // -----------------------------------------------------------------
    logic [cog_pkg::TS_W-1:0] rec_time [cog_pkg::RECORDS];  // Time stamps.
    logic [2:0] rec_group [cog_pkg::RECORDS];  // Group in use, 0 is group 1.
    logic [cog_pkg::REL_W-1:0] rec_rem [cog_pkg::RECORDS];  // Remaining time.
    logic [cog_pkg::REL_W-1:0] rec_act [cog_pkg::RECORDS];  // Elapsed time.
    logic [3:0] wr_ptr;  // Next slot, wraps over the oldest.
    wire rec_we = rise[cog_pkg::EV_ACTIVE];  // Activation ON.
    wire [3:0] last_slot = 4'(cog_pkg::RECORDS - 1);  // Wrap point.

    // Write pointer and fill count.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            wr_ptr <= 4'h0;
            o_record_count <= 4'h0;
        end else if (rec_we) begin
            wr_ptr <= (wr_ptr == last_slot) ? 4'h0 : wr_ptr + 4'h1;  // see R12
            if (o_record_count != 4'(cog_pkg::RECORDS)) begin
                o_record_count <= o_record_count + 4'h1;
            end
        end
    end

    // Record storage; no reset needed as the count qualifies it. (see R13)
    always_ff @(posedge i_clock) begin
        if (rec_we) begin
            rec_time[wr_ptr] <= i_timestamp;
            rec_group[wr_ptr] <= i_setting_group_choice;
            rec_rem[wr_ptr] <= rel_time - elapsed;
            rec_act[wr_ptr] <= elapsed;
        end
    end

    // Read slot: index 0 is the newest record.
    wire [4:0] rd_sum = {1'b0, wr_ptr} + 5'(cog_pkg::RECORDS) - {1'b0, i_record_index} - 5'h01;
    wire [4:0] rd_wrap = (rd_sum >= 5'(cog_pkg::RECORDS)) ? rd_sum - 5'(cog_pkg::RECORDS) : rd_sum;
    wire [3:0] rd_slot = rd_wrap[3:0];
    wire rd_ok = (i_record_index < o_record_count);  // Valid entry selected.

    // Registered record read port; empty slots read as zero.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_record_time <= '0;
            o_record_event <= 2'h0;
            o_record_group <= 3'h0;
            o_record_remaining <= '0;
            o_record_elapsed <= '0;
        end else if (rd_ok) begin
            o_record_time <= rec_time[rd_slot];
            o_record_event <= 2'(cog_pkg::EV_ACTIVE);
            o_record_group <= rec_group[rd_slot];
            o_record_remaining <= rec_rem[rd_slot];
            o_record_elapsed <= rec_act[rd_slot];
        end else begin
            o_record_time <= '0;
            o_record_event <= 2'h0;
            o_record_group <= 3'h0;
            o_record_remaining <= '0;
            o_record_elapsed <= '0;
        end
    end

endmodule // cog_guard

// File: cog_pkg.sv
// Constants, encodings and timing counts of the close-onto-fault guard.
// Assumes a single 25 MHz clock and a millisecond time base derived from it.
//
// Function
// (R1) Rising activation edge arms guard, starts countdown.
// (R2) Trigger while armed trips at once.
// (R3) Armed period equals chosen release time.
// (R4) Block input stops arming and tripping.
// (R5) Trip output opens the breaker directly.
// (R6) Only binary inputs, no analog measurement.
// (R7) Mode setting, default On, echoed as behaviour.
// (R8) Forced status overrides reported status.
// (R9) Condition reports Normal/Init/Active/Trip/Blocked.
// (R10) ON/OFF events, per-event store selection.
// (R11) Clearable cumulative counter per event.
// (R12) Twelve records, oldest overwritten on activation.
// (R13) Record: time, event, group, remaining, elapsed.
// (R14) Setting group change applies while running.
// (R15) Expiry drops active, needs new edge; a trigger held at expiry keeps the guard tripped until it drops.
// (R16) Off/Blocked suppress; Test reports, no trip.
package cog_pkg;

    // -------------------------------------------------------------
    // Timing.
    // -------------------------------------------------------------
    localparam int CLOCK_HZ = 25_000_000;  // System clock rate.
    localparam int TICK_MS = 1;  // Time base step in milliseconds.
    localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;  // Cycles per millisecond.
    localparam int REL_W = 21;  // Width of a time in milliseconds.
    localparam logic [20:0] REL_MAX_MS = 21'h1B7740;  // 1800.000 s longest release.
    localparam logic [20:0] REL_DEF_MS = 21'h0003E8;  // 1.000 s default release.

    // -------------------------------------------------------------
    // Sizes.
    // -------------------------------------------------------------
    localparam int GROUPS = 8;  // Setting groups.
    localparam int RECORDS = 12;  // Records kept.
    localparam int CNT_W = 16;  // Counter width.
    localparam int TS_W = 64;  // Time stamp width.

    // -------------------------------------------------------------
    // Event indices, also the record event code.
    // -------------------------------------------------------------
    localparam int EV_INIT = 0;  // Init event.
    localparam int EV_BLOCK = 1;  // Block event.
    localparam int EV_ACTIVE = 2;  // Active event.
    localparam int EV_TRIP = 3;  // Trip event.

    // Operating mode codes.
    typedef enum logic [2:0] {
        COG_MODE_ON = 3'h0,
        COG_MODE_BLOCKED = 3'h1,
        COG_MODE_TEST = 3'h2,
        COG_MODE_TEST_BLOCKED = 3'h3,
        COG_MODE_OFF = 3'h4
    } cog_mode_t;

    // Forced status codes.
    typedef enum logic [1:0] {
        COG_FORCE_NORMAL = 2'h0,
        COG_FORCE_BLOCKED = 2'h1,
        COG_FORCE_ACTIVE = 2'h2,
        COG_FORCE_TRIP = 2'h3
    } cog_force_t;

    // Reported condition codes.
    typedef enum logic [2:0] {
        COG_COND_NORMAL = 3'h0,
        COG_COND_INIT = 3'h1,
        COG_COND_ACTIVE = 3'h2,
        COG_COND_TRIP = 3'h3,
        COG_COND_BLOCKED = 3'h4
    } cog_cond_t;

    // Guard states, one-hot.
    typedef enum logic [2:0] {
        COG_ST_IDLE = 3'h1,
        COG_ST_ARMED = 3'h2,
        COG_ST_TRIPPED = 3'h4
    } cog_state_t;

endpackage

// File: cog_guard_asserts.sv
// Port checker of the close-onto-fault guard, bound to the guard.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps

module cog_guard_asserts (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_arming_input,
    input wire logic i_guard_block_input,
    input wire logic i_fault_trigger_input,
    input wire logic [2:0] i_mode,
    input wire logic [1:0] i_force,
    input wire logic [3:0] i_event_on_store,
    input wire logic o_guard_trip_output,
    input wire logic o_guard_armed_output,
    input wire logic [cog_pkg::REL_W-1:0] o_release_time_remaining,
    input wire logic [2:0] o_behaviour,
    input wire logic [2:0] o_condition,
    input wire logic [3:0] o_event_on
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic [7:0] arm_hist; // Recent activation pin levels, newest in bit 0.

    // Shifts the pin in so that an arming can be traced to its edge.
    always_ff @(posedge i_clock) begin
        arm_hist <= i_srst ? 8'h00 : {arm_hist[6:0], i_arming_input};
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    // Three cycles spent in a test mode.
    sequence s_test_held;
        (i_mode == 3'h2 || i_mode == 3'h3) [*3];
    endsequence

    // Six cycles with the block pin high.
    sequence s_block_held;
        i_guard_block_input [*6];
    endsequence

    arm_edge_a: assert property (
        $rose(o_guard_armed_output) && $past(i_force) == 2'h0
        |-> arm_hist[1] && !(&arm_hist[7:3])) else $error("armed without an edge");
    trip_cause_a: assert property (
        $rose(o_guard_trip_output) && $past(i_force) == 2'h0
        |-> $past(i_fault_trigger_input, 3)) else $error("trip without trigger");
    test_no_trip_a: assert property (
        s_test_held |-> !o_guard_trip_output) else $error("trip in test mode");
    block_no_arm_a: assert property (
        s_block_held |-> !o_guard_armed_output) else $error("armed while blocked");
    idle_remain_a: assert property (
        !o_guard_armed_output && !$past(o_guard_armed_output)
        |-> o_release_time_remaining == 21'h0) else $error("remaining time when idle");
    trip_cond_a: assert property (
        o_guard_trip_output && $past(o_guard_trip_output)
        |-> o_condition == 3'h3) else $error("trip not shown");
    trip_event_a: assert property (
        $rose(o_guard_trip_output) && i_event_on_store[3]
        |-> o_event_on[3]) else $error("no trip event");
    mode_echo_a: assert property (
        !$past(i_srst) && $stable(i_mode) && i_mode <= 3'h4
        |-> o_behaviour == i_mode) else $error("behaviour differs");
endmodule // cog_guard_asserts

bind cog_guard cog_guard_asserts u_asserts (
    .i_clock(i_clock), .i_srst(i_srst), .i_arming_input(i_arming_input),
    .i_guard_block_input(i_guard_block_input), .i_fault_trigger_input(i_fault_trigger_input),
    .i_mode(i_mode), .i_force(i_force), .i_event_on_store(i_event_on_store),
    .o_guard_trip_output(o_guard_trip_output), .o_guard_armed_output(o_guard_armed_output),
    .o_release_time_remaining(o_release_time_remaining), .o_behaviour(o_behaviour),
    .o_condition(o_condition), .o_event_on(o_event_on)
);

// File: cog_fault_source.sv
// Model of the breaker close command and the protection stage start.
// Assumes bench commands change shortly after a rising edge.
`timescale 1ns/1ps

module cog_fault_source (
    input wire logic i_clock,
    input wire logic i_close_cmd,
    input wire logic i_start_cmd,
    input wire logic [1:0] i_lag,
    output logic o_close_pin,
    output logic o_start_pin
);
    logic [2:0] close_dly; // Close command delay line.
    logic [2:0] start_dly; // Start command delay line.

    // Delays both commands so that the pins answer at once or slowly.
    always_ff @(posedge i_clock) begin
        close_dly <= {close_dly[1:0], i_close_cmd};
        start_dly <= {start_dly[1:0], i_start_cmd};
    end

    // Lag zero passes a command straight through.
    assign o_close_pin = (i_lag == 2'h0) ? i_close_cmd : close_dly[i_lag - 2'h1];
    assign o_start_pin = (i_lag == 2'h0) ? i_start_cmd : start_dly[i_lag - 2'h1];
endmodule // cog_fault_source

// File: cog_guard_tb.sv
// Self-checking bench of the close-onto-fault guard against a scoreboard.
// Assumes the package, guard, checker and fault source are compiled first.
`timescale 1ns/1ps

module cog_guard_tb;
    localparam int T = 4; // Cycles per time step in this run.
    logic i_clock, i_srst, blk, close_cmd, start_cmd, arm_pin, start_pin, trip, armed;
    logic [1:0] lag, frc, r_ev;
    logic [2:0] mode, grp, beh, cond, r_grp;
    logic [3:0] on_st, clr, ridx, rcnt, ev_off;
    logic [20:0] r_rem, r_el;
    logic [63:0] ts, cnts;
    logic [167:0] rel_set;
    logic [7:0] seed; // Random source state.
    int err_total, n_checks, recs, trips, lat, g;
    int rel[8]; // Release time of each group in steps.
    int grp_q[$]; // Groups of the records written, oldest first.

    cog_guard #(.TICK_CYCLES(T)) u_dut (
        .i_clock(i_clock), .i_srst(i_srst), .i_arming_input(arm_pin),
        .i_guard_block_input(blk), .i_fault_trigger_input(start_pin), .i_mode(mode),
        .i_force(frc), .i_setting_group_choice(grp), .i_release_time_setting(rel_set),
        .i_timestamp(ts), .i_event_on_store(on_st), .i_event_off_store(on_st),
        .i_counter_clear(clr), .i_record_index(ridx), .o_guard_trip_output(trip),
        .o_guard_armed_output(armed), .o_release_time_remaining(), .o_active_time(),
        .o_behaviour(beh), .o_condition(cond), .o_event_on(), .o_event_off(ev_off),
        .o_event_time(), .o_counters(cnts), .o_record_count(rcnt), .o_record_time(),
        .o_record_event(r_ev), .o_record_group(r_grp), .o_record_remaining(r_rem),
        .o_record_elapsed(r_el));
    cog_fault_source u_src (.i_clock(i_clock), .i_close_cmd(close_cmd),
        .i_start_cmd(start_cmd), .i_lag(lag), .o_close_pin(arm_pin), .o_start_pin(start_pin));

    // Clock and a free-running time stamp.
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    always @(posedge i_clock) ts <= #2 (i_srst ? 64'h0 : ts + 64'h1);

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Waits n edges, then steps just past the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #2;
    endtask
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        // An unknown result counts as a mismatch.
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    // Counts cycles until trip or armed reaches a level, up to a bound.
    task automatic wait_out(input logic sel, input logic lvl, input int lim, output int n);
        n = 0;
        while ((sel ? trip : armed) !== lvl && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge i_clock);
        err_total++;
        test_done();
    end

    // Main sequence.
    initial begin
        {blk, close_cmd, start_cmd, lag, frc, mode, grp, clr, ridx} = '0;
        on_st = 4'hF;
        seed = 8'h2A;
        i_srst = 1'b1;
        for (g = 0; g < 8; g++) begin
            seed = lfsr(seed);
            rel[g] = 6 + int'(seed[2:0]);
            rel_set[g*21 +: 21] = 21'(rel[g]);
        end
        tick(5);
        chk({trip, armed, beh, cond, rcnt} === 12'h0 && cnts === 64'h0, "reset");
        i_srst = 1'b0;
        tick(3);
        // Arms fourteen times: even passes trip, odd passes run out.
        for (int k = 0; k < 14; k++) begin
            seed = lfsr(seed);
            lag = seed[1:0];
            grp = seed[4:2];
            on_st = seed[7:4];
            close_cmd = 1'b1;
            wait_out(1'b0, 1'b1, 12, lat);
            recs++;
            grp_q.push_back(int'(grp));
            chk(lat <= int'(lag) + 6, "arming late");
            tick(2);
            chk(rcnt === 4'(recs > 12 ? 12 : recs), "record count");
            chk(cnts[32 +: 16] === 16'(recs), "active counter");
            chk({r_ev, r_grp, r_rem, r_el} === {2'h2, grp, 21'(rel[grp]), 21'h0}, "record");
            if (k % 2 == 0) begin
                start_cmd = 1'b1;
                wait_out(1'b1, 1'b1, 12, lat);
                trips++;
                chk(lat <= int'(lag) + 6 && cond === 3'h3, "no instant trip");
                tick(1);
                chk(cnts[48 +: 16] === 16'(trips), "trip counter");
                start_cmd = 1'b0;
                wait_out(1'b1, 1'b0, 80, lat);
                // The period must run out, or the next rising edge is ignored.
                wait_out(1'b0, 1'b0, 80, lat);
                chk(armed === 1'b0, "armed stuck");
            end else begin
                wait_out(1'b0, 1'b0, 80, lat);
                chk(ev_off === (on_st & 4'h4), "active off event");
                chk(lat >= (rel[grp] - 1) * T - 3 && lat <= rel[grp] * T, "armed time");
                start_cmd = 1'b1;
                tick(12);
                chk(armed === 1'b0 && trip === 1'b0, "trip after expiry");
                start_cmd = 1'b0;
            end
            close_cmd = 1'b0;
            tick(8);
        end
        ridx = 4'hB;
        tick(2);
        g = grp_q[grp_q.size() - 12];
        chk(r_grp === 3'(g) && r_rem === 21'(rel[g]), "oldest record");
        blk = 1'b1;
        close_cmd = 1'b1;
        start_cmd = 1'b1;
        tick(14);
        chk(armed === 1'b0 && trip === 1'b0 && cond === 3'h4, "blocked");
        chk(cnts[16 +: 16] === 16'h1, "block counter");
        {blk, close_cmd, start_cmd} = 3'h0;
        tick(6);
        clr = 4'hF;
        tick(2);
        clr = 4'h0;
        tick(1);
        chk(cnts === 64'h0, "counter clear");
        // Each mode with an arming and a start together.
        for (int m = 0; m < 5; m++) begin
            mode = 3'(m);
            tick(3);
            chk(beh === 3'(m), "behaviour");
            close_cmd = 1'b1;
            start_cmd = 1'b1;
            tick(14);
            chk(trip === 1'(m == 0), "trip by mode");
            chk(m == 4 || cond === (m % 2 == 1 ? 3'h4 : 3'h3), "mode condition");
            {close_cmd, start_cmd} = 2'h0;
            tick(60);
        end
        mode = 3'h0;
        for (int f = 1; f < 4; f++) begin
            frc = 2'(f);
            tick(3);
            chk(cond === (f == 1 ? 3'h4 : f == 2 ? 3'h2 : 3'h3), "forced status");
        end
        frc = 2'h0;
        tick(3);
        chk(cond === 3'h0 && trip === 1'b0, "force released");
        // A shorter group chosen while armed ends the period early.
        rel_set[20:0] = 21'h28;
        rel_set[41:21] = 21'h6;
        grp = 3'h0;
        close_cmd = 1'b1;
        wait_out(1'b0, 1'b1, 12, lat);
        tick(4 * T);
        grp = 3'h1;
        wait_out(1'b0, 1'b0, 80, lat);
        chk(lat <= 3 * T + 2, "group change ignored");
        test_done();
    end
endmodule // cog_guard_tb
